// >>> vbl_pkg.sv
// Shared constants, types and helpers of the vector bitwise logic unit
package vbl_pkg;
  localparam logic [7:0]  VBL_CTRL_OFFS   = 8'h00;
  localparam logic [7:0]  VBL_STAT_OFFS   = 8'h04;
  localparam int          VBL_OP_LSB      = 0;
  localparam int          VBL_OP_W        = 3;
  localparam int          VBL_ALIGN_BIT   = 3;
  localparam int          VBL_VALID_BIT   = 0;
  localparam int          VBL_FRAC_LSB    = 8;
  localparam logic [31:0] VBL_CTRL_RESET  = 32'h0000_0008;
  localparam int          VBL_LATENCY     = 1;

  typedef enum logic [2:0] {
    VBL_AND  = 3'h0,
    VBL_NAND = 3'h1,
    VBL_OR   = 3'h2,
    VBL_NOR  = 3'h3,
    VBL_XOR  = 3'h4,
    VBL_XNOR = 3'h5
  } vbl_op_type;

  typedef enum logic [1:0] {
    VBL_PH_IDLE  = 2'h0,
    VBL_PH_WRITE = 2'h1,
    VBL_PH_READ  = 2'h3
  } vbl_phase_type;

  // Base operator of the family, before any final inversion
  function automatic logic vbl_bit_op(input vbl_op_type op, input logic a, input logic b);
    case (op)
      VBL_OR, VBL_NOR:   vbl_bit_op = a | b;
      VBL_XOR, VBL_XNOR: vbl_bit_op = a ^ b;
      default:           vbl_bit_op = a & b;
    endcase
  endfunction : vbl_bit_op

  function automatic logic vbl_inverts(input vbl_op_type op);
    vbl_inverts = (op == VBL_NAND) || (op == VBL_NOR) || (op == VBL_XNOR);
  endfunction : vbl_inverts

  function automatic logic vbl_op_legal(input logic [2:0] code);
    vbl_op_legal = (code <= 3'h5);
  endfunction : vbl_op_legal
endpackage : vbl_pkg

// >>> vbl_lane_if.sv
// Carrier between the top and one sample lane
`timescale 1ns/1ps
`default_nettype none
interface vbl_lane_if
  import vbl_pkg::*;
#(
  parameter int NUM_IN = 2,
  parameter int AW     = 16,
  parameter int OW     = 16
);
  logic [NUM_IN*AW-1:0] opnd;
  vbl_op_type           op;
  logic [OW-1:0]        res;
  modport core (input opnd, input op, output res);
  modport feed (output opnd, output op, input res);
endinterface : vbl_lane_if
`default_nettype wire

// >>> vbl_lane.sv
// One sample lane: multi-input bitwise combine or single-input reduction
`timescale 1ns/1ps
`default_nettype none
module vbl_lane
  import vbl_pkg::*;
#(
  parameter int NUM_IN = 2,
  parameter int AW     = 16,
  parameter int OW     = 16
) (
  vbl_lane_if.core lif
);
  always_comb begin
    logic [AW-1:0] acc;
    logic          red;
    acc = lif.opnd[AW-1:0];
    red = lif.opnd[0];
    if (NUM_IN == 1) begin
      for (int b = 1; b < AW; b++) begin
        red = vbl_bit_op(lif.op, red, lif.opnd[b]);
      end
      red = red ^ vbl_inverts(lif.op);
      lif.res = OW'(red);
    end else begin
      for (int i = 1; i < NUM_IN; i++) begin
        for (int b = 0; b < AW; b++) begin
          acc[b] = vbl_bit_op(lif.op, acc[b], lif.opnd[i*AW+b]);
        end
      end
      // Result as wide as aligned operands
      lif.res = OW'(acc ^ {AW{vbl_inverts(lif.op)}});
    end
  end
endmodule : vbl_lane
`default_nettype wire

// >>> vbl_top.sv
// Vector bitwise logic unit with AHB-Lite control registers
//
// How it works
// - One operator: AND NAND OR NOR XOR XNOR
// - One to 1024 inputs, all combined
// - Zero-pad fraction, sign-extend integer to align
// - Fixed-point operands, result on one port
// - Single input reduces operand to one bit
// - Reduction chains from LSB upward
// - Reduction output is always one bit
// - Every sample of vector processed each period
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vbl_top
  import vbl_pkg::*;
#(
  parameter int NUM_IN  = 2,
  parameter int SAMPLES = 1,
  parameter int IN_W    = 8,
  parameter int FW      = $clog2(IN_W + 1),
  parameter int AW      = 2 * IN_W,
  parameter int OW      = (NUM_IN == 1) ? 1 : AW
) (
  input  wire  logic                          sys_clk,
  input  wire  logic                          nrst,
  input  wire  logic                          ce,
  input  wire  logic                          hsel,
  input  wire  logic [31:0]                   haddr,
  input  wire  logic [1:0]                    htrans,
  input  wire  logic                          hwrite,
  input  wire  logic [2:0]                    hsize,
  input  wire  logic [31:0]                   hwdata,
  input  wire  logic                          hready,
  output logic       [31:0]                   hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  input  wire  logic                          in_valid,
  input  wire  logic [SAMPLES*NUM_IN*IN_W-1:0] opnd_data,
  input  wire  logic [NUM_IN*FW-1:0]          opnd_frac,
  input  wire  logic [NUM_IN-1:0]             opnd_signed,
  output logic                                res_valid,
  output logic       [SAMPLES*OW-1:0]         res_data,
  output logic       [FW-1:0]                 res_frac
);
  // Bus slave state
  vbl_phase_type ph_q, ph_d;
  logic [7:0]    addr_q, addr_d;
  logic [31:0]   rdata_q, rdata_d;
  logic [3:0]    ctrl_q, ctrl_d;
  // Datapath state
  logic                  valid_q, valid_d;
  logic [SAMPLES*OW-1:0] res_q, res_d;
  logic [FW-1:0]         frac_q, frac_d;

  logic [SAMPLES*NUM_IN*AW-1:0] aligned;
  logic [SAMPLES*OW-1:0]        lane_res;
  logic [FW-1:0]                fmax;
  logic                         take;

  // Lane width: a reduction sees the operand alone, without padding
  localparam int LW = (NUM_IN == 1) ? IN_W : AW;

  vbl_op_type op_cfg;
  logic       align_en;
  assign op_cfg   = vbl_op_type'(ctrl_q[VBL_OP_LSB +: VBL_OP_W]);
  assign align_en = ctrl_q[VBL_ALIGN_BIT];

  // Extend one operand to the common format
  function automatic logic [AW-1:0] vbl_align(input logic [IN_W-1:0] x, input logic sgn,
                                              input logic [FW-1:0] sh);
    logic [AW-1:0] ext;
    ext = sgn ? AW'($signed(x)) : AW'(x);
    vbl_align = ext << sh;
  endfunction : vbl_align

  // Largest fraction sets the common point
  always_comb begin
    fmax = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (opnd_frac[i*FW +: FW] > fmax) begin
        fmax = opnd_frac[i*FW +: FW];
      end
    end
  end

  always_comb begin
    logic [FW-1:0] sh;
    sh = '0;
    aligned = '0;
    for (int s = 0; s < SAMPLES; s++) begin
      for (int i = 0; i < NUM_IN; i++) begin
        // No shift when alignment is off
        sh = align_en ? FW'(fmax - opnd_frac[i*FW +: FW]) : '0;
        aligned[(s*NUM_IN+i)*AW +: AW] =
          vbl_align(opnd_data[(s*NUM_IN+i)*IN_W +: IN_W], opnd_signed[i], sh);
      end
    end
  end

  for (genvar s = 0; s < SAMPLES; s++) begin : g_lane
    vbl_lane_if #(.NUM_IN(NUM_IN), .AW(LW), .OW(OW)) lif ();
    // Single input reduces the raw operand bits
    if (NUM_IN == 1) begin : g_raw
      assign lif.opnd = opnd_data[s*IN_W +: IN_W];
    end else begin : g_algn
      assign lif.opnd = aligned[s*NUM_IN*AW +: NUM_IN*AW];
    end
    assign lif.op   = op_cfg;
    assign lane_res[s*OW +: OW] = lif.res;
    vbl_lane #(.NUM_IN(NUM_IN), .AW(LW), .OW(OW)) u_lane (
      .lif (lif.core)
    );
  end

  always_comb begin
    valid_d = valid_q;
    res_d   = res_q;
    frac_d  = frac_q;
    if (ce) begin
      valid_d = in_valid;
      if (in_valid) begin
        res_d  = lane_res;
        frac_d = align_en ? fmax : opnd_frac[FW-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      valid_q <= 1'b0;
      res_q   <= '0;
      frac_q  <= '0;
    end else begin
      valid_q <= valid_d;
      res_q   <= res_d;
      frac_q  <= frac_d;
    end
  end

  // Bus: address phase taken, data phase with zero wait
  assign take = hsel && hready && htrans[1] && ce;

  always_comb begin
    ph_d    = ph_q;
    addr_d  = addr_q;
    rdata_d = rdata_q;
    ctrl_d  = ctrl_q;
    if (ce) begin
      if (ph_q == VBL_PH_WRITE && addr_q == VBL_CTRL_OFFS &&
          vbl_op_legal(hwdata[VBL_OP_LSB +: VBL_OP_W])) begin
        ctrl_d = hwdata[3:0];
      end
      ph_d = VBL_PH_IDLE;
      if (take) begin
        ph_d   = hwrite ? VBL_PH_WRITE : VBL_PH_READ;
        addr_d = {haddr[7:2], 2'b00};
      end
      rdata_d = '0;
      if (take && !hwrite) begin
        case ({haddr[7:2], 2'b00})
          VBL_CTRL_OFFS: rdata_d = {28'h0, ctrl_d};
          VBL_STAT_OFFS: begin
            rdata_d[VBL_VALID_BIT]         = valid_q;
            rdata_d[VBL_FRAC_LSB +: FW]    = frac_q;
          end
          default:       rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ph_q    <= VBL_PH_IDLE;
      addr_q  <= '0;
      rdata_q <= '0;
      ctrl_q  <= VBL_CTRL_RESET[3:0];
    end else begin
      ph_q    <= ph_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign res_valid = valid_q;
  assign res_data  = res_q;
  assign res_frac  = frac_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_op_legal: assert property (vbl_op_legal(ctrl_q[2:0]))
    else $error("illegal operator held");
  chk_valid_latency: assert property (ce && in_valid |=> res_valid)
    else $error("result valid missing one cycle after input");
  chk_valid_drop: assert property (ce && !in_valid |=> !res_valid)
    else $error("result valid without input");
  chk_freeze_hold: assert property (!ce |=> $stable(res_data) && $stable(res_valid))
    else $error("state moved while clock enable low");
  chk_align_point: assert property (ce && in_valid && align_en |=> res_frac == $past(fmax))
    else $error("aligned binary point wrong");
  chk_noalign_point: assert property (ce && in_valid && !align_en
      |=> res_frac == $past(opnd_frac[FW-1:0]))
    else $error("unaligned binary point wrong");
  if (NUM_IN == 1) begin : g_red_chk
    chk_reduce_and: assert property (ce && in_valid && op_cfg == VBL_AND
        |=> res_data[0] == $past(&opnd_data[IN_W-1:0]))
      else $error("and reduction mismatch");
    chk_reduce_xor: assert property (ce && in_valid && op_cfg == VBL_XOR
        |=> res_data[0] == $past(^opnd_data[IN_W-1:0]))
      else $error("xor reduction mismatch");
    chk_reduce_nand: assert property (ce && in_valid && op_cfg == VBL_NAND
        |=> res_data[0] == $past(~&opnd_data[IN_W-1:0]))
      else $error("nand reduction mismatch");
  end else if (NUM_IN == 2) begin : g_multi_chk
    chk_multi_and: assert property (ce && in_valid && op_cfg == VBL_AND
        |=> res_data[AW-1:0] == $past(aligned[AW-1:0] & aligned[2*AW-1:AW]))
      else $error("two-input and mismatch");
  end
  chk_read_ctrl: assert property (take && !hwrite && haddr[7:0] == VBL_CTRL_OFFS
      |=> hrdata[3:0] == $past(ctrl_d))
    else $error("control readback wrong");

  cov_reduction: cover property (NUM_IN == 1 && ce && in_valid ##1 res_valid);
  cov_nor_op: cover property (op_cfg == VBL_NOR && ce && in_valid);
  cov_ctrl_write: cover property (take && hwrite ##1 ph_q == VBL_PH_WRITE);
  cov_mixed_points: cover property (align_en && in_valid && fmax != opnd_frac[FW-1:0]);
endmodule : vbl_top
`default_nettype wire

// >>> vbl_feed.sv
// Upstream datapath model that presents operand words to the unit
`timescale 1ns/1ps
`default_nettype none
module vbl_feed #(
  parameter int N = 2
) (
  input  wire logic           clk,
  output logic                vld,
  output logic [N*8-1:0]      dat,
  output logic [N*4-1:0]      frc,
  output logic [N-1:0]        sgn
);
  initial begin
    vld = 1'b0;
    dat = '0;
    frc = '0;
    sgn = '0;
  end

  task automatic send(input logic [N*8-1:0] d, input logic [N*4-1:0] f, input logic [N-1:0] s);
    @(posedge clk);
    vld <= 1'b1;
    dat <= d;
    frc <= f;
    sgn <= s;
    @(posedge clk);
    vld <= 1'b0;
    // Released data shows no stale value
    dat <= ~d;
  endtask : send
endmodule : vbl_feed
`default_nettype wire

// >>> vbl_tb_top.sv
// Self-checking testbench of the vector bitwise logic unit
`timescale 1ns/1ps
`default_nettype none
module vbl_tb_top;
  import vbl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = '0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic        ce      = 1'b1;
  logic [2:0]  hsize   = 3'h0;
  logic [31:0] hwdata  = '0;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, vld, rvld, res_valid, red_valid;
  logic [15:0] dat, res_data;
  logic [7:0]  frc, rdat;
  logic [3:0]  rfrc, res_frac, red_frac;
  logic [1:0]  sgn;
  logic        rsgn;
  logic [0:0]  red_data;
  int          bad_count  = 0;
  int          num_checks = 0;

  always #25 sys_clk = ~sys_clk;

  vbl_feed #(.N(2)) feed (.clk(sys_clk), .vld(vld), .dat(dat), .frc(frc), .sgn(sgn));
  vbl_feed #(.N(1)) rfeed (.clk(sys_clk), .vld(rvld), .dat(rdat), .frc(rfrc), .sgn(rsgn));

  vbl_top #(.NUM_IN(2)) uut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .in_valid(vld),
    .opnd_data(dat), .opnd_frac(frc), .opnd_signed(sgn), .res_valid(res_valid),
    .res_data(res_data), .res_frac(res_frac));

  vbl_top #(.NUM_IN(1)) red (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .hsel(1'b0),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(), .hreadyout(), .hresp(), .in_valid(rvld),
    .opnd_data(rdat), .opnd_frac(rfrc), .opnd_signed(rsgn), .res_valid(red_valid),
    .res_data(red_data), .res_frac(red_frac));

  task automatic close_out;
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      bad_count++;
      close_out();
    end
  endtask : wait_ready

  // Entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus

  function automatic logic [15:0] ext(input logic [7:0] d, input logic s, input int sh);
    return {{8{s & d[7]}}, d} << sh;
  endfunction : ext

  task automatic check_regs;
    bus(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h8);
    chk(hresp, 1'b0);
    bus(1'b0, 32'h4, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, 32'h10, 32'h0, rd);
    chk(rd, 32'h0);
  endtask : check_regs

  task automatic run_ops;
    logic [15:0] a, b, e;
    a = ext(8'h96, 1'b1, 0);
    b = ext(8'h3c, 1'b0, 2);
    for (int op = 0; op < 6; op++) begin
      @(posedge sys_clk);
      bus(1'b1, 32'h0, 32'h8 | op, rd);
      e = (op < 2) ? (a & b) : (op < 4) ? (a | b) : (a ^ b);
      if (op % 2 == 1) begin
        e = ~e;
      end
      feed.send({8'h3c, 8'h96}, {4'h0, 4'h2}, 2'b01);
      @(negedge sys_clk);
      chk(res_data, e);
      chk(res_frac, 4'h2);
      chk(res_valid, 1'b1);
      @(negedge sys_clk);
      chk(res_valid, 1'b0);
    end
  endtask : run_ops

  task automatic align_off;
    @(posedge sys_clk);
    bus(1'b1, 32'h0, 32'he, rd);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'hd);
    bus(1'b1, 32'h0, 32'h4, rd);
    feed.send({8'h3c, 8'h96}, {4'h3, 4'h3}, 2'b00);
    @(negedge sys_clk);
    chk(res_data, 16'h00aa);
    chk(res_frac, 4'h3);
    @(posedge sys_clk);
    bus(1'b0, 32'h4, 32'h0, rd);
    chk(rd & 32'hf00, 32'h300);
  endtask : align_off

  // Frozen by clock enable, then reset in mid-run
  task automatic freeze_reset;
    @(posedge sys_clk);
    ce <= 1'b0;
    feed.send({8'h0f, 8'hf0}, {4'h0, 4'h0}, 2'b00);
    @(negedge sys_clk);
    chk(res_valid, 1'b0);
    chk(res_data, 16'h00aa);
    @(posedge sys_clk);
    ce   <= 1'b1;
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk(res_data, 16'h0000);
    @(posedge sys_clk);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h8);
  endtask : freeze_reset

  task automatic reduce;
    rfeed.send(8'hff, 4'h0, 1'b0);
    @(negedge sys_clk);
    chk(red_data, 1'b1);
    chk(red_valid, 1'b1);
    rfeed.send(8'hfe, 4'h5, 1'b0);
    @(negedge sys_clk);
    chk(red_data, 1'b0);
    chk(red_frac, 4'h5);
  endtask : reduce

  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    check_regs();
    run_ops();
    align_off();
    freeze_reset();
    reduce();
    close_out();
  end
endmodule : vbl_tb_top
`default_nettype wire
